/* File: mdf_dma_arbiter.sv */
// Central transmit and receive buffers, burst sizing and arbiters of the DMA engine
// How it works
// - Tx buffer 128 words, four programmable sections
// - Section capped at 124; host keeps sum
// - Complete frame present starts forwarding early
// - Fill above forward threshold starts forwarding
// - Both conditions rechecked after each frame
// - Empty section refills until full
// - Refetch only once fill drops below refill
// - Tx burst limited by free space, 15/4
// - Serial FIFOs served whenever they show space
// - Shared rx buffer, one host threshold
// - Move all data within one bus tenure
// - Bus groups: vectors, descriptors, receive, then transmit
// - Round robin within transmit group, per access; receive follows buffer order
// - Optional high-priority channel in transmit group and serial arbiters
// - Separate serial tx and rx arbiters
// - Descriptor bursts 3 words, data up to 15
// - Rx burst of one channel, serial threshold limit
// - Demux mode: bursts of 4 or single
// - Back-to-back bursts inside one tenure
// - Byte swap only on data sections
// - Started frame ignores forward threshold
// - Forward threshold zero forwards at once
`timescale 1ns/100ps
`include "mdf_defines.svh"

module mdf_fifo #(
    parameter int W = 34,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } mdf_fifo_st_t;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("mdf_fifo depth must be a power of two of at least 2");
    end

    mdf_fifo_st_t s;
    mdf_fifo_st_t next_s;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = s.cnt != (AW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data = mem[s.rd];
    assign level = s.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
        if (push) begin
            mem[s.wr] <= in_data;
        end
    end
endmodule

module mdf_dma_arbiter #(
    parameter int TX_DWORDS = `MDF_TX_DWORDS,
    parameter int RX_DEPTH = `MDF_RX_DEPTH,
    parameter int STAGE_DEPTH = `MDF_STAGE_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0][7:0] tx_section_size_config,
    input wire logic [3:0][7:0] tx_refill_threshold_config,
    input wire logic [3:0][7:0] tx_forward_threshold_config,
    input wire logic [7:0] rx_threshold_config,
    input wire logic [7:0] scc_rx_threshold_config,
    input wire logic priority_channel_enable,
    input wire logic [1:0] priority_channel_select,
    input wire logic endian_swap_enable,
    input wire logic demux_mode,
    input wire logic demux_burst_off,
    input wire logic ivec_req,
    input wire logic [31:0] ivec_data,
    input wire logic desc_req,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic bus_start,
    output logic bus_end,
    output mdf_pkg::mdf_kind_t bus_kind,
    output logic [1:0] bus_chan,
    output logic [3:0] bus_len,
    input wire logic bus_beat,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_rdata_fe,
    output logic [31:0] bus_wdata,
    input wire logic [3:0] scc_tx_ready,
    output logic scc_tx_valid,
    output logic [1:0] scc_tx_chan,
    output logic [31:0] scc_tx_data,
    output logic scc_tx_fe,
    input wire logic [3:0] scc_rx_valid,
    input wire logic [3:0][31:0] scc_rx_data,
    output logic [3:0] scc_rx_ready,
    output logic [3:0][7:0] tx_section_fill
);
    if (TX_DWORDS > 128 || TX_DWORDS <= 124 || STAGE_DEPTH < 2 || RX_DEPTH < 16) begin : g_bad
        $error("mdf_dma_arbiter parameters outside the supported range");
    end

    localparam int RLW = $clog2(RX_DEPTH) + 1;
    localparam int SLW = $clog2(STAGE_DEPTH) + 1;

    mdf_pkg::mdf_state_t s;
    mdf_pkg::mdf_state_t n;
    mdf_pkg::mdf_tx_word_t tx_mem [TX_DWORDS];
    mdf_pkg::mdf_tx_word_t tx_rd_word;
    mdf_pkg::mdf_rx_word_t stage_in;
    mdf_pkg::mdf_rx_word_t stage_out;
    mdf_pkg::mdf_rx_word_t rx_head;
    logic stage_in_valid, stage_in_ready, stage_out_valid, rx_in_ready, rx_valid, rx_pop;
    logic [SLW-1:0] stage_level;
    logic [RLW-1:0] rx_level;
    logic [3:0][7:0] size_eff, base, free;
    logic [3:0] tx_want, fwd_start, can_fwd, tx_push, tx_pop;
    logic [2:0] txs, tx_grp, rxs;
    logic [3:0] maxb;
    logic [7:0] scc_lim, rx_len;
    logic [6:0] tx_rd_addr, tx_wr_addr;
    logic push_beat, rx_req, ivec_ok, desc_ok, has_req, rx_break, xfer_done;
    logic [1:0] rx_src;

    // Section layout and per-channel flow conditions
    for (genvar c = 0; c < 4; c++) begin : g_sect
        assign size_eff[c] = mdf_pkg::mdf_min(tx_section_size_config[c], `MDF_SECT_MAX);
        if (c == 0) begin : g_b0
            assign base[c] = 8'h00;
        end else begin : g_bn
            assign base[c] = base[c-1] + size_eff[c-1];
        end
        assign free[c] = size_eff[c] - s.sect[c].fill;
        assign tx_want[c] = s.sect[c].refill && free[c] != 8'h00;
        // A zero threshold makes any stored word enough to start
        assign fwd_start[c] = s.sect[c].fes != 8'h00
            || s.sect[c].fill > tx_forward_threshold_config[c];
        // Serial side is served whenever it shows room, powered down or not
        assign can_fwd[c] = (s.sect[c].fwd || fwd_start[c])
            && s.sect[c].fill != 8'h00 && scc_tx_ready[c];
    end

    assign maxb = demux_mode ? (demux_burst_off ? `MDF_BURST_SINGLE : `MDF_BURST_DEMUX)
        : `MDF_BURST_PCI;
    // Small serial thresholds fragment the shared buffer, so bursts follow them
    assign scc_lim = (scc_rx_threshold_config != 8'h00
        && scc_rx_threshold_config < 8'(`MDF_BURST_PCI)) ? scc_rx_threshold_config : 8'hff;
    assign rx_len = mdf_pkg::mdf_min(mdf_pkg::mdf_min(8'(rx_level), 8'(maxb)), scc_lim);

    assign txs = mdf_pkg::mdf_rr_pick(can_fwd, s.txs_rr, priority_channel_enable,
                                      priority_channel_select);
    assign tx_grp = mdf_pkg::mdf_rr_pick(tx_want, s.tx_rr, priority_channel_enable,
                                         priority_channel_select);
    assign rxs = mdf_pkg::mdf_rr_pick(scc_rx_valid, s.rxs_rr, priority_channel_enable,
                                      priority_channel_select);

    assign tx_rd_addr = 7'(base[txs[1:0]] + {1'b0, s.sect[txs[1:0]].rd});
    assign tx_wr_addr = 7'(base[s.chan] + {1'b0, s.sect[s.chan].wr});
    assign tx_rd_word = tx_mem[tx_rd_addr];
    assign tx_pop = txs[2] ? (4'h1 << txs[1:0]) : 4'h0;
    assign push_beat = s.st == mdf_pkg::MDF_XFER && s.kind == mdf_pkg::MDF_K_TX && bus_beat;
    assign tx_push = push_beat ? (4'h1 << s.chan) : 4'h0;

    // A vector or descriptor just finished is not reissued in the cycle its burst ends
    assign ivec_ok = ivec_req && !(s.done && s.kind == mdf_pkg::MDF_K_IVEC);
    assign desc_ok = desc_req && !(s.done && s.kind == mdf_pkg::MDF_K_DESC);
    assign rx_req = rx_level != '0 && 8'(rx_level) >= rx_threshold_config;
    assign has_req = ivec_ok || desc_ok || rx_req || tx_grp[2];
    // A receive burst stops at the first word of another channel
    assign rx_break = s.kind == mdf_pkg::MDF_K_RX && (!rx_valid || rx_head.chan != s.chan);
    assign rx_pop = s.st == mdf_pkg::MDF_XFER && s.kind == mdf_pkg::MDF_K_RX && bus_beat
        && !rx_break;
    assign xfer_done = !bus_gnt || rx_break || (bus_beat && s.left == 4'h1);

    // Serial receive words enter a small staging FIFO, then the shared buffer
    always_comb begin
        rx_src = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (s.rx_ready[i]) begin
                rx_src = 2'(i);
            end
        end
    end
    assign stage_in_valid = |(scc_rx_valid & s.rx_ready);
    assign stage_in = '{data: scc_rx_data[rx_src], chan: rx_src};

    mdf_fifo #(.W(`MDF_RX_WORD_W), .DEPTH(STAGE_DEPTH)) u_stage (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(stage_in_valid),
        .in_data(stage_in),
        .in_ready(stage_in_ready),
        .out_valid(stage_out_valid),
        .out_data(stage_out),
        .out_ready(rx_in_ready),
        .level(stage_level)
    );

    mdf_fifo #(.W(`MDF_RX_WORD_W), .DEPTH(RX_DEPTH)) u_central_rx_buffer (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(stage_out_valid),
        .in_data(stage_out),
        .in_ready(rx_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_head),
        .out_ready(rx_pop),
        .level(rx_level)
    );

    always_comb begin
        logic [7:0] nf;
        nf = 8'h00;
        n = s;
        n.start = 1'b0;
        n.done = 1'b0;
        n.out_valid = 1'b0;
        // Serial transmit side
        if (txs[2]) begin
            n.out_valid = 1'b1;
            n.out_chan = txs[1:0];
            n.out_word = tx_rd_word;
            n.txs_rr = txs[1:0];
        end
        for (int c = 0; c < 4; c++) begin
            nf = s.sect[c].fill + 8'(tx_push[c]) - 8'(tx_pop[c]);
            n.sect[c].fill = nf;
            n.sect[c].fes = s.sect[c].fes + 8'(tx_push[c] && bus_rdata_fe)
                - 8'(tx_pop[c] && tx_rd_word.fe);
            if (tx_push[c]) begin
                n.sect[c].wr = (8'(s.sect[c].wr) + 8'h01 >= size_eff[c]) ? 7'h00
                    : s.sect[c].wr + 7'h01;
            end
            if (tx_pop[c]) begin
                n.sect[c].rd = (8'(s.sect[c].rd) + 8'h01 >= size_eff[c]) ? 7'h00
                    : s.sect[c].rd + 7'h01;
                n.sect[c].fwd = !tx_rd_word.fe;
            end
            if (nf == 8'h00) begin
                n.sect[c].refill = 1'b1;
            end else if (nf >= size_eff[c]) begin
                n.sect[c].refill = 1'b0;
            end else if (nf < tx_refill_threshold_config[c]) begin
                n.sect[c].refill = 1'b1;
            end
        end
        // Serial receive side: ready is granted only while the stage surely has room
        if (stage_in_valid) begin
            n.rxs_rr = rx_src;
        end
        n.rx_ready = 4'h0;
        if (rxs[2] && 32'(stage_level) + 32'(stage_in_valid) < STAGE_DEPTH) begin
            n.rx_ready = 4'h1 << rxs[1:0];
        end
        // Host bus side
        case (s.st)
            mdf_pkg::MDF_IDLE: begin
                if (has_req) begin
                    n.st = mdf_pkg::MDF_REQ;
                end
            end
            mdf_pkg::MDF_REQ: begin
                if (!has_req) begin
                    n.st = mdf_pkg::MDF_IDLE;
                end else if (bus_gnt) begin
                    n.st = mdf_pkg::MDF_XFER;
                    n.start = 1'b1;
                    if (ivec_ok) begin
                        n.kind = mdf_pkg::MDF_K_IVEC;
                        n.chan = 2'h0;
                        n.len = `MDF_IVEC_BURST;
                    end else if (desc_ok) begin
                        n.kind = mdf_pkg::MDF_K_DESC;
                        n.chan = 2'h0;
                        n.len = `MDF_DESC_BURST;
                    end else if (rx_req) begin
                        n.kind = mdf_pkg::MDF_K_RX;
                        n.chan = rx_head.chan;
                        n.len = rx_len[3:0];
                    end else begin
                        n.kind = mdf_pkg::MDF_K_TX;
                        n.chan = tx_grp[1:0];
                        n.len = 4'(mdf_pkg::mdf_min(free[tx_grp[1:0]], 8'(maxb)));
                    end
                    n.left = n.len;
                end
            end
            mdf_pkg::MDF_XFER: begin
                if (bus_beat && !rx_break) begin
                    n.left = s.left - 4'h1;
                end
                if (xfer_done) begin
                    // Bus stays requested so the next burst follows in the same tenure
                    n.st = mdf_pkg::MDF_REQ;
                    n.done = 1'b1;
                    if (s.kind == mdf_pkg::MDF_K_TX) begin
                        n.tx_rr = s.chan;
                    end
                end
            end
            default: begin
                n.st = mdf_pkg::MDF_IDLE;
            end
        endcase
        n.req = n.st != mdf_pkg::MDF_IDLE;
        // Vectors go out as stored, only data words are swapped
        n.wdata = (n.kind == mdf_pkg::MDF_K_RX) ? mdf_pkg::mdf_swap(rx_head.data,
            endian_swap_enable) : ivec_data;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= mdf_pkg::MDF_IDLE;
            for (int c = 0; c < 4; c++) begin
                s.sect[c].refill <= `MDF_REFILL_RST;
            end
        end else begin
            s <= n;
        end
        if (push_beat) begin
            tx_mem[tx_wr_addr] <= '{data: mdf_pkg::mdf_swap(bus_rdata, endian_swap_enable),
                                    fe: bus_rdata_fe};
        end
    end

    assign bus_req = s.req;
    assign bus_start = s.start;
    assign bus_end = s.done;
    assign bus_kind = s.kind;
    assign bus_chan = s.chan;
    assign bus_len = s.len;
    assign bus_wdata = s.wdata;
    assign scc_tx_valid = s.out_valid;
    assign scc_tx_chan = s.out_chan;
    assign scc_tx_data = s.out_word.data;
    assign scc_tx_fe = s.out_word.fe;
    assign scc_rx_ready = s.rx_ready;
    for (genvar c = 0; c < 4; c++) begin : g_fill
        assign tx_section_fill[c] = s.sect[c].fill;
    end

    // Checks
    logic [3:0] fwd_ok_q;
    always_ff @(posedge clk) begin
        fwd_ok_q <= fwd_start | {s.sect[3].fwd, s.sect[2].fwd, s.sect[1].fwd, s.sect[0].fwd};
    end

    sequence grant_taken;
        s.st == mdf_pkg::MDF_REQ && bus_gnt && has_req;
    endsequence

    sequence burst_opens(mdf_pkg::mdf_kind_t k);
        bus_start && bus_kind == k;
    endsequence

    burst_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
        bus_start |-> bus_len != 4'h0 && bus_len <= maxb)
        else $error("burst length outside limit");
    vec_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        grant_taken and ivec_ok |=> burst_opens(mdf_pkg::MDF_K_IVEC))
        else $error("vector transfer not served first");
    rx_before_tx_a: assert property (@(posedge clk) disable iff (sys_rst)
        grant_taken and (!ivec_ok && !desc_ok && rx_req) |=> burst_opens(mdf_pkg::MDF_K_RX))
        else $error("receive group lost to transmit");
    desc_burst_a: assert property (@(posedge clk) disable iff (sys_rst)
        burst_opens(mdf_pkg::MDF_K_DESC) |-> bus_len == 4'h3)
        else $error("descriptor burst not three words");
    rx_burst_a: assert property (@(posedge clk) disable iff (sys_rst)
        burst_opens(mdf_pkg::MDF_K_RX) |-> 8'(bus_len) <= scc_lim && bus_chan == rx_head.chan)
        else $error("receive burst exceeds serial threshold");
    tenure_chain_a: assert property (@(posedge clk) disable iff (sys_rst)
        bus_end && bus_gnt |-> bus_req ##1 (bus_start || !$past(has_req) || !$past(bus_gnt)))
        else $error("next burst not issued back to back");
    fwd_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        scc_tx_valid |-> fwd_ok_q[scc_tx_chan])
        else $error("forwarding without frame end or threshold");
    vec_unswapped_a: assert property (@(posedge clk) disable iff (sys_rst)
        burst_opens(mdf_pkg::MDF_K_IVEC) |-> bus_wdata == $past(ivec_data))
        else $error("vector word altered");
    prio_serial_a: assert property (@(posedge clk) disable iff (sys_rst)
        priority_channel_enable && can_fwd[priority_channel_select]
        |=> scc_tx_valid && scc_tx_chan == $past(priority_channel_select))
        else $error("priority channel not served first");
    for (genvar c = 0; c < 4; c++) begin : g_chk
        sect_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
            s.sect[c].fill <= size_eff[c])
            else $error("section overfilled");
        rearm_a: assert property (@(posedge clk) disable iff (sys_rst)
            scc_tx_valid && scc_tx_fe && scc_tx_chan == 2'(c) |-> !s.sect[c].fwd)
            else $error("forwarding kept active past frame end");
        refill_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
            $rose(s.sect[c].refill) |-> s.sect[c].fill < tx_refill_threshold_config[c]
                || s.sect[c].fill == 8'h00)
            else $error("refill resumed above threshold");
    end
endmodule

/* File: mdf_defines.svh */
// Constants of the multichannel DMA FIFO and arbiter block
`ifndef MDF_DEFINES_SVH
`define MDF_DEFINES_SVH
`define MDF_CHANNELS 4
`define MDF_TX_DWORDS 128
`define MDF_SECT_MAX 8'd124
`define MDF_BURST_PCI 4'hf
`define MDF_BURST_DEMUX 4'h4
`define MDF_BURST_SINGLE 4'h1
`define MDF_DESC_BURST 4'h3
`define MDF_IVEC_BURST 4'h1
`define MDF_RX_DEPTH 64
`define MDF_STAGE_DEPTH 4
`define MDF_WORD_W 32
`define MDF_RX_WORD_W 34
`define MDF_REFILL_RST 1'b1
`endif

/* File: mdf_pkg.sv */
// Types shared by the multichannel DMA FIFO and arbiter block
package mdf_pkg;
    typedef enum logic [2:0] {
        MDF_IDLE = 3'h1,
        MDF_REQ = 3'h2,
        MDF_XFER = 3'h4
    } mdf_bus_st_t;

    typedef enum logic [3:0] {
        MDF_K_NONE = 4'h0,
        MDF_K_IVEC = 4'h1,
        MDF_K_DESC = 4'h2,
        MDF_K_RX = 4'h4,
        MDF_K_TX = 4'h8
    } mdf_kind_t;

    typedef struct packed {
        logic [6:0] wr;
        logic [6:0] rd;
        logic [7:0] fill;
        logic [7:0] fes;
        logic fwd;
        logic refill;
    } mdf_sect_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] chan;
    } mdf_rx_word_t;

    typedef struct packed {
        logic [31:0] data;
        logic fe;
    } mdf_tx_word_t;

    typedef struct packed {
        mdf_bus_st_t st;
        logic req;
        mdf_kind_t kind;
        logic [1:0] chan;
        logic [3:0] len;
        logic [3:0] left;
        logic start;
        logic done;
        logic [31:0] wdata;
        logic [1:0] tx_rr;
        logic [1:0] txs_rr;
        logic [1:0] rxs_rr;
        mdf_sect_t [3:0] sect;
        logic out_valid;
        logic [1:0] out_chan;
        mdf_tx_word_t out_word;
        logic [3:0] rx_ready;
    } mdf_state_t;

    // Reverses the four bytes of a data word when swapping is on
    function automatic logic [31:0] mdf_swap(input logic [31:0] d, input logic en);
        return en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // Fixed high-priority channel first, then round robin after the last one served
    function automatic logic [2:0] mdf_rr_pick(input logic [3:0] req, input logic [1:0] last,
                                               input logic pen, input logic [1:0] psel);
        logic [2:0] r;
        logic [1:0] idx;
        r = 3'h0;
        idx = 2'h0;
        if (pen && req[psel]) begin
            r = {1'b1, psel};
        end else begin
            for (int i = 4; i >= 1; i--) begin
                idx = last + 2'(i);
                if (req[idx]) begin
                    r = {1'b1, idx};
                end
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] mdf_min(input logic [7:0] a, input logic [7:0] b);
        return (a < b) ? a : b;
    endfunction
endpackage

/* File: mdf_host_model.sv */
// Host bus responder that grants the bus and paces data phases
`timescale 1ns/100ps
module mdf_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_req,
    input wire logic bus_start,
    input wire logic bus_end,
    input wire logic [3:0] bus_len,
    input wire logic slow,
    output logic bus_gnt,
    output logic bus_beat,
    output logic [31:0] bus_rdata,
    output logic bus_rdata_fe
);
    logic [3:0] left;
    logic [1:0] gap;
    logic [7:0] cnt;
    always @(posedge clk) begin
        if (sys_rst) begin
            bus_gnt <= 1'b0;
            bus_beat <= 1'b0;
            bus_rdata <= 32'h0;
            bus_rdata_fe <= 1'b0;
            left <= 4'h0;
            gap <= 2'h0;
            cnt <= 8'h0;
        end else begin
            // Grant is kept for an open burst so the tenure is not cut short
            bus_gnt <= bus_req | (left != 4'h0);
            bus_beat <= 1'b0;
            // Idle data lines invert each cycle, so they match the last word every second idle cycle
            bus_rdata <= ~bus_rdata;
            bus_rdata_fe <= 1'b0;
            if (bus_start) begin
                left <= bus_len;
                gap <= 2'h1;
            end else if (bus_end) begin
                left <= 4'h0;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end else if (left != 4'h0) begin
                bus_beat <= 1'b1;
                bus_rdata <= 32'h00010203 + {4{cnt}};
                bus_rdata_fe <= (left == 4'h1);
                left <= left - 4'h1;
                cnt <= cnt + 8'h1;
                gap <= slow ? 2'h2 : 2'h1;
            end
        end
    end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the DMA buffer and arbiter block
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0][7:0] tx_section_size_config = '0, tx_refill_threshold_config = '0;
    logic [3:0][7:0] tx_forward_threshold_config = '0, tx_section_fill;
    logic [7:0] rx_threshold_config = 8'h02, scc_rx_threshold_config = 8'h00;
    logic priority_channel_enable = 1'b0, endian_swap_enable = 1'b1, demux_mode = 1'b0;
    logic demux_burst_off = 1'b0, ivec_req = 1'b0, desc_req = 1'b0, slow = 1'b0;
    logic [1:0] priority_channel_select = 2'h0, bus_chan, scc_tx_chan;
    logic [31:0] ivec_data = 32'h0, bus_rdata, bus_wdata, scc_tx_data, vec_w, rx_w;
    logic [3:0] scc_tx_ready = 4'h0, scc_rx_valid = 4'h0, bus_len, scc_rx_ready;
    logic [3:0][31:0] scc_rx_data = '0;
    logic bus_req, bus_gnt, bus_start, bus_end, bus_beat, bus_rdata_fe, scc_tx_valid, scc_tx_fe;
    logic rx_seen = 1'b0;
    mdf_pkg::mdf_kind_t bus_kind;
    logic [3:0] st_len[$];
    logic [3:0] st_kind[$];
    int err_total = 0;
    int tests_run = 0;

    initial forever #2.5 clk = ~clk;

    mdf_dma_arbiter dut_u (.clk, .sys_rst, .tx_section_size_config, .tx_refill_threshold_config,
        .tx_forward_threshold_config, .rx_threshold_config, .scc_rx_threshold_config,
        .priority_channel_enable, .priority_channel_select, .endian_swap_enable, .demux_mode,
        .demux_burst_off, .ivec_req, .ivec_data, .desc_req, .bus_req, .bus_gnt, .bus_start,
        .bus_end, .bus_kind, .bus_chan, .bus_len, .bus_beat, .bus_rdata, .bus_rdata_fe,
        .bus_wdata, .scc_tx_ready, .scc_tx_valid, .scc_tx_chan, .scc_tx_data, .scc_tx_fe,
        .scc_rx_valid, .scc_rx_data, .scc_rx_ready, .tx_section_fill);
    mdf_host_model host_u (.clk, .sys_rst, .bus_req, .bus_start, .bus_end, .bus_len, .slow,
        .bus_gnt, .bus_beat, .bus_rdata, .bus_rdata_fe);

    always @(posedge clk) begin
        if (bus_start) begin
            st_len.push_back(bus_len);
            st_kind.push_back(bus_kind);
        end
        if (bus_beat && bus_kind == mdf_pkg::MDF_K_IVEC) vec_w <= bus_wdata;
        if (bus_beat && bus_kind == mdf_pkg::MDF_K_RX && !rx_seen) begin
            rx_w <= bus_wdata;
            rx_seen <= 1'b1;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Serial side takes words until the section drops to the given level
    task drain_to(input logic [7:0] lv);
        @(negedge clk);
        scc_tx_ready[0] = 1'b1;
        for (int i = 0; i < 400 && tx_section_fill[0] > lv; i++) @(negedge clk);
        scc_tx_ready[0] = 1'b0;
    endtask
    task wait_kind(input logic [3:0] k);
        for (int i = 0; i < 400 && bus_kind !== k; i++) @(negedge clk);
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        err_total++;
        $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        wrap_up();
    end

    initial begin
        int n;
        int m;
        tx_section_size_config[0] = 8'd20;
        tx_refill_threshold_config[0] = 8'd5;
        tx_forward_threshold_config[0] = 8'd3;
        repeat (6) @(negedge clk);
        chk(32'(bus_req), 32'h0);
        chk(32'(bus_kind), 32'h0);
        sys_rst = 1'b0;
        for (int i = 0; i < 400 && tx_section_fill[0] != 8'd20; i++) @(negedge clk);
        repeat (20) @(negedge clk);
        chk(32'(tx_section_fill[0]), 32'd20);
        chk(32'(st_len.size()), 32'd2);
        chk(32'(st_len[0]), 32'd15);
        chk(32'(st_len[1]), 32'd5);
        $display("test fill done");
        scc_tx_ready[0] = 1'b1;
        for (int i = 0; i < 100 && scc_tx_valid !== 1'b1; i++) @(negedge clk);
        chk(scc_tx_data, 32'h03020100);
        chk(32'(scc_tx_chan), 32'h0);
        drain_to(8'd16);
        repeat (40) @(negedge clk);
        chk(32'(st_len.size()), 32'd2);
        drain_to(8'd3);
        repeat (300) @(negedge clk);
        chk(32'(tx_section_fill[0]), 32'd20);
        chk(32'(st_kind[st_kind.size()-1]), 32'h8);
        $display("test forward done");
        n = st_kind.size();
        ivec_data = 32'h11223344;
        ivec_req = 1'b1;
        desc_req = 1'b1;
        wait_kind(4'h1);
        ivec_req = 1'b0;
        wait_kind(4'h2);
        desc_req = 1'b0;
        chk(32'(bus_len), 32'h3);
        repeat (20) @(negedge clk);
        chk(32'(st_kind[n]), 32'h1);
        chk(vec_w, 32'h11223344);
        scc_rx_data[1] = 32'haabbccdd;
        scc_rx_valid[1] = 1'b1;
        m = 0;
        for (int i = 0; i < 100 && m < 3; i++) begin
            @(negedge clk);
            if (scc_rx_ready[1] === 1'b1) m++;
        end
        scc_rx_valid[1] = 1'b0;
        repeat (60) @(negedge clk);
        chk(rx_w, 32'hddccbbaa);
        $display("test vector and receive done");
        demux_mode = 1'b1;
        priority_channel_enable = 1'b1;
        slow = 1'b1;
        n = st_len.size();
        drain_to(8'd3);
        repeat (300) @(negedge clk);
        chk(32'(st_len[n]), 32'h4);
        demux_burst_off = 1'b1;
        n = st_len.size();
        drain_to(8'd3);
        repeat (300) @(negedge clk);
        chk(32'(st_len[n]), 32'h1);
        $display("test demux done");
        wrap_up();
    end
endmodule
